// ===== lccs_pkg.sv
// Purpose: Shared constants for the LCD clock, contrast and segment configuration block
// Assumes: Register port with 8-bit data in the low bits of the word
// Notes:   Offsets are word indices on the plain register port
package lccs_pkg;
   // Register offsets
   localparam logic [3:0] ADDR_CONTRAST  = 4'h0;
   localparam logic [3:0] ADDR_CONTROL   = 4'h1;
   localparam logic [3:0] ADDR_PRESCALE  = 4'h2;
   localparam logic [3:0] ADDR_SEG_EN    = 4'h3;
   localparam logic [3:0] ADDR_PIXEL     = 4'h4;
   localparam logic [3:0] ADDR_STATUS    = 4'h5;
   // Control register field positions
   localparam int CS_LSB     = 0;
   localparam int BIAS_LSB   = 2;
   localparam int ENABLE_BIT = 4;
   localparam int HALF_BIT   = 5;
   localparam int SLEEP_BIT  = 6;
   // Reset values
   localparam logic [7:0] CONTRAST_RST = 8'h00;
   localparam logic [7:0] CONTROL_RST  = 8'h00;
   localparam logic [7:0] PRESCALE_RST = 8'h00;
   localparam logic [7:0] SEG_EN_RST   = 8'h00;
   localparam logic [7:0] PIXEL_RST    = 8'h00;
   localparam logic [7:0] CONTRAST_MASK = 8'h07;
   // Fixed system clock divider
   localparam int         SYS_DIV       = 256;
   localparam logic [7:0] SYS_DIV_LAST  = 8'hff;
   // Ladder taps in sevenths
   localparam logic [2:0] LADDER_SHORT = 3'h0;
   localparam logic [2:0] LADDER_FULL  = 3'h7;
   // Clock source selection
   typedef enum logic [1:0] {
      SRC_SYS_DIV = 2'b00,
      SRC_XTAL    = 2'b01,
      SRC_LFOSC   = 2'b10,
      SRC_RSVD    = 2'b11
   } lccs_src_t;
   // Bias type selection
   typedef enum logic [1:0] {
      BIAS_STATIC = 2'b00,
      BIAS_HALF   = 2'b01,
      BIAS_THIRD  = 2'b10,
      BIAS_RSVD   = 2'b11
   } lccs_bias_t;
endpackage : lccs_pkg

// ===== lccs_src_mux.sv
// Purpose: Selects one of the three LCD clock sources as a tick
// Assumes: Oscillator ticks arrive as one-cycle pulses synchronous to core_clk
// Notes:   The reserved selection gives no tick
`timescale 1ns/10ps
module lccs_src_mux
   import lccs_pkg::*;
(
   input  wire logic            core_clk,
   input  wire logic            reset,
   input  wire lccs_pkg::lccs_src_t src_sel,
   input  wire logic            sleep,
   input  wire logic            xtal_tick,
   input  wire logic            lfosc_tick,
   output logic                 src_tick
);
   import lccs_pkg::*;

   logic [7:0] sys_cnt_r;
   logic [7:0] sys_cnt_nxt;
   logic       sys_tick;

   // Fixed divide by the system divider, halted in sleep
   assign sys_cnt_nxt = sleep ? sys_cnt_r : sys_cnt_r + 8'h01;
   assign sys_tick    = !sleep && (sys_cnt_r == SYS_DIV_LAST);

   always_ff @(posedge core_clk) begin
      if (reset) sys_cnt_r <= 8'h00;
      else       sys_cnt_r <= sys_cnt_nxt;
   end

   // Source choice; oscillator ticks pass even in sleep
   assign src_tick = (src_sel == SRC_SYS_DIV) ? sys_tick :
                     (src_sel == SRC_XTAL)    ? xtal_tick :
                     (src_sel == SRC_LFOSC)   ? lfosc_tick :
                     1'b0;

   property p_sys_period;
      @(posedge core_clk) disable iff (reset)
      (sys_tick && !sleep) |=> !sys_tick [*8];
   endproperty
   a_sys_period: assert property (p_sys_period) else $error("system divider ticked early");
endmodule : lccs_src_mux

// ===== lccs_prescaler.sv
// Purpose: Four-bit prescaler that turns source ticks into frame ticks
// Assumes: restart is a one-cycle pulse on selection change, and is held high while the LCD is disabled
// Notes:   Counter is hidden from software
`timescale 1ns/10ps
module lccs_prescaler
   import lccs_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic       reset,
   input  wire logic       restart,
   input  wire logic [3:0] ratio,
   input  wire logic       src_tick,
   output logic            frame_tick
);
   import lccs_pkg::*;

   logic [3:0] cnt_r;
   logic [3:0] cnt_nxt;
   logic       wrap;
   logic       frame_r;

   // Ratio field n gives divide by n+1
   assign wrap    = src_tick && (cnt_r >= ratio);
   assign cnt_nxt = restart ? 4'h0 : wrap ? 4'h0 : src_tick ? cnt_r + 4'h1 : cnt_r;

   always_ff @(posedge core_clk) begin
      if (reset) begin
         cnt_r   <= 4'h0;
         frame_r <= 1'b0;
      end else begin
         cnt_r   <= cnt_nxt;
         frame_r <= wrap && !restart;
      end
   end
   assign frame_tick = frame_r;

   property p_restart_clears;
      @(posedge core_clk) disable iff (reset)
      restart |=> (cnt_r == 4'h0) && !frame_tick;
   endproperty
   a_restart_clears: assert property (p_restart_clears) else $error("restart left count");

   // A new ratio may leave the count above it for the one restart cycle only
   property p_ratio_bound;
      @(posedge core_clk) disable iff (reset)
      !restart |-> cnt_r <= ratio;
   endproperty
   a_ratio_bound: assert property (p_ratio_bound) else $error("count out of range");
endmodule : lccs_prescaler

// ===== lccs_top.sv
// Purpose: LCD clock selection, prescaler, contrast, segment and bias configuration
// Assumes: Plain register port, read data one cycle after read strobe
// Notes:   Analog ladder is represented by digital control outputs only
// Behaviour
// - Contrast code zero shorts the contrast ladder for maximum contrast.
// - Nonzero contrast code n sets ladder to n sevenths of full resistance.
// - Contrast register upper five bits read zero; low three writable.
// - Segment enable one gives pin to LCD, zero keeps GPIO.
// - Two-bit source field chooses among three LCD clock sources.
// - First source is system clock divided by fixed 256.
// - Third source is low-frequency internal oscillator, about 1 kHz out.
// - Oscillator sources keep LCD running during sleep.
// - Hidden four-bit prescaler divides selected clock by the prescale field plus one.
// - Prescale ratios span divide-by-one through divide-by-sixteen.
// - Static, half and third bias give two, three, four levels.
// - Inactive module switches internal bias ladder off.
// - Half bias shorts middle ladder resistor.
`timescale 1ns/10ps
module lccs_top
   import lccs_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic       reset,
   input  wire logic [3:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic [7:0]      reg_rdata,
   input  wire logic       cpu_sleep,
   input  wire logic       xtal_tick,
   input  wire logic       lfosc_tick,
   input  wire logic       xtal_enabled,
   output logic            frame_tick,
   output logic [2:0]      ladder_tap,
   output logic            ladder_short,
   output logic [7:0]      segment_pin_enable,
   output logic [7:0]      pixel_on_bit,
   output logic [1:0]      bias_levels_m1,
   output logic            bias_ladder_on,
   output logic            mid_resistor_short,
   output logic            lcd_active_flag
);
   import lccs_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Register storage
   logic [7:0] contrast_ladder_ctrl_r;
   logic [7:0] lcd_control_reg_r;
   logic [7:0] lcd_phase_prescale_reg_r;
   logic [7:0] segment_pin_enable_r;
   logic [7:0] pixel_data_r;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   logic       restart_r;
   logic       restart_nxt;

   // Write decode
   logic wr_contrast;
   logic wr_control;
   logic wr_prescale;
   logic wr_seg;
   logic wr_pixel;

   function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   assign wr_contrast = reg_wr && hit(reg_addr, ADDR_CONTRAST);
   assign wr_control  = reg_wr && hit(reg_addr, ADDR_CONTROL);
   assign wr_prescale = reg_wr && hit(reg_addr, ADDR_PRESCALE);
   assign wr_seg      = reg_wr && hit(reg_addr, ADDR_SEG_EN);
   assign wr_pixel    = reg_wr && hit(reg_addr, ADDR_PIXEL);

   ////////////////////////////////////////////////////////////////////////
   // Fields
   lccs_src_t  src_sel;
   lccs_bias_t bias_sel;
   logic       lcd_enable;
   logic       half_bias_select;
   logic [3:0] frame_prescale_select;
   logic       sel_change;

   assign src_sel               = lccs_src_t'(lcd_control_reg_r[CS_LSB +: 2]);
   assign bias_sel              = lccs_bias_t'(lcd_control_reg_r[BIAS_LSB +: 2]);
   assign lcd_enable            = lcd_control_reg_r[ENABLE_BIT];
   assign half_bias_select      = lcd_control_reg_r[HALF_BIT];
   assign frame_prescale_select = lcd_phase_prescale_reg_r[3:0];

   // Restart the prescaler whenever source or ratio is rewritten with a new value
   assign sel_change = (wr_control &&
                        (reg_wdata[CS_LSB +: 2] != lcd_control_reg_r[CS_LSB +: 2])) ||
                       (wr_prescale && (reg_wdata[3:0] != frame_prescale_select));
   assign restart_nxt = sel_change;

   // Register writes; the mask drops unimplemented contrast bits
   always_ff @(posedge core_clk) begin
      if (reset) begin
         contrast_ladder_ctrl_r   <= CONTRAST_RST;
         lcd_control_reg_r        <= CONTROL_RST;
         lcd_phase_prescale_reg_r <= PRESCALE_RST;
         segment_pin_enable_r     <= SEG_EN_RST;
         pixel_data_r             <= PIXEL_RST;
         restart_r                <= 1'b0;
      end else begin
         if (wr_contrast) contrast_ladder_ctrl_r <= reg_wdata & CONTRAST_MASK;
         if (wr_control)  lcd_control_reg_r      <= reg_wdata & 8'h7f;
         if (wr_prescale) lcd_phase_prescale_reg_r <= reg_wdata & 8'h0f;
         if (wr_seg)      segment_pin_enable_r   <= reg_wdata;
         if (wr_pixel)    pixel_data_r           <= reg_wdata;
         restart_r <= restart_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read path; status shows active flag and oscillator readiness
   logic [7:0] status_word;
   assign status_word = {5'h00, xtal_enabled, frame_tick, lcd_active_flag};

   assign rdata_nxt = !reg_rd                          ? 8'h00 :
                      hit(reg_addr, ADDR_CONTRAST)     ? (contrast_ladder_ctrl_r & CONTRAST_MASK) :
                      hit(reg_addr, ADDR_CONTROL)      ? lcd_control_reg_r :
                      hit(reg_addr, ADDR_PRESCALE)     ? lcd_phase_prescale_reg_r :
                      hit(reg_addr, ADDR_SEG_EN)       ? segment_pin_enable_r :
                      hit(reg_addr, ADDR_PIXEL)        ? pixel_data_r :
                      hit(reg_addr, ADDR_STATUS)       ? status_word :
                      8'h00;

   always_ff @(posedge core_clk) begin
      if (reset) rdata_r <= 8'h00;
      else       rdata_r <= rdata_nxt;
   end
   assign reg_rdata = rdata_r;

   ////////////////////////////////////////////////////////////////////////
   // Clock chain; sleep halts only the system-derived source
   logic src_tick;
   logic frame_raw;

   lccs_src_mux i_lccs_src_mux (
      .core_clk   (core_clk),
      .reset      (reset),
      .src_sel    (src_sel),
      .sleep      (cpu_sleep),
      .xtal_tick  (xtal_tick),      // software must enable the oscillator first
      .lfosc_tick (lfosc_tick),
      .src_tick   (src_tick)
   );

   lccs_prescaler i_lccs_prescaler (
      .core_clk   (core_clk),
      .reset      (reset),
      .restart    (restart_r || !lcd_enable),
      .ratio      (frame_prescale_select),
      .src_tick   (src_tick && lcd_enable),
      .frame_tick (frame_raw)
   );
   assign frame_tick = frame_raw;

   ////////////////////////////////////////////////////////////////////////
   // Contrast, segment, pixel and bias outputs
   logic [1:0] levels_nxt;
   logic       active_r;

   assign ladder_short       = (contrast_ladder_ctrl_r[2:0] == LADDER_SHORT);
   assign ladder_tap         = contrast_ladder_ctrl_r[2:0];
   assign segment_pin_enable = segment_pin_enable_r;
   assign pixel_on_bit       = pixel_data_r;

   // Levels minus one: static 1, half 2, third 3
   assign levels_nxt = (bias_sel == BIAS_STATIC) ? 2'd1 :
                       (bias_sel == BIAS_HALF)   ? 2'd2 : 2'd3;

   // Active flag follows enable; low in sleep on the system source
   always_ff @(posedge core_clk) begin
      if (reset) active_r <= 1'b0;
      else       active_r <= lcd_enable && !(cpu_sleep && src_sel == SRC_SYS_DIV);
   end
   assign lcd_active_flag    = active_r;
   assign bias_levels_m1     = levels_nxt;
   assign bias_ladder_on     = active_r;
   assign mid_resistor_short = active_r && half_bias_select;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   property p_short_zero;
      @(posedge core_clk) disable iff (reset)
      ladder_short == (ladder_tap == 3'h0);
   endproperty
   a_short_zero: assert property (p_short_zero) else $error("short mismatch");

   property p_tap_write;
      @(posedge core_clk) disable iff (reset)
      wr_contrast |=> ladder_tap == $past(reg_wdata[2:0]);
   endproperty
   a_tap_write: assert property (p_tap_write) else $error("tap not written");

   property p_contrast_rd;
      @(posedge core_clk) disable iff (reset)
      (reg_rd && reg_addr == ADDR_CONTRAST) |=> reg_rdata[7:3] == 5'h00;
   endproperty
   a_contrast_rd: assert property (p_contrast_rd) else $error("upper contrast bits set");

   property p_seg_write;
      @(posedge core_clk) disable iff (reset)
      wr_seg |=> segment_pin_enable == $past(reg_wdata);
   endproperty
   a_seg_write: assert property (p_seg_write) else $error("segment enable not written");

   property p_pix_write;
      @(posedge core_clk) disable iff (reset)
      wr_pixel |=> pixel_on_bit == $past(reg_wdata);
   endproperty
   a_pix_write: assert property (p_pix_write) else $error("pixel not written");

   property p_ladder_off;
      @(posedge core_clk) disable iff (reset)
      !lcd_enable |=> !bias_ladder_on && !mid_resistor_short;
   endproperty
   a_ladder_off: assert property (p_ladder_off) else $error("ladder on while inactive");

   property p_half_short;
      @(posedge core_clk) disable iff (reset)
      (lcd_enable && half_bias_select && !cpu_sleep && !wr_control) |=> mid_resistor_short;
   endproperty
   a_half_short: assert property (p_half_short) else $error("middle resistor not shorted");

   property p_levels;
      @(posedge core_clk) disable iff (reset)
      (bias_sel == BIAS_HALF) |-> bias_levels_m1 == 2'd2;
   endproperty
   a_levels: assert property (p_levels) else $error("half bias level count wrong");

   property p_sleep_run;
      @(posedge core_clk) disable iff (reset)
      (lcd_enable && cpu_sleep && src_sel == SRC_LFOSC) |=> lcd_active_flag;
   endproperty
   a_sleep_run: assert property (p_sleep_run) else $error("stopped in sleep");

   ////////////////////////////////////////////////////////////////////////
   // Register port: stored values hold between writes, idle reads give zero
   property p_tap_hold;
      @(posedge core_clk) disable iff (reset)
      !wr_contrast |=> $stable(ladder_tap);
   endproperty
   a_tap_hold: assert property (p_tap_hold) else $error("tap drifted");

   property p_contrast_val;
      @(posedge core_clk) disable iff (reset)
      (reg_rd && reg_addr == ADDR_CONTRAST) |=> reg_rdata[2:0] == ladder_tap;
   endproperty
   a_contrast_val: assert property (p_contrast_val) else $error("readback wrong");

   property p_seg_hold;
      @(posedge core_clk) disable iff (reset)
      !wr_seg |=> $stable(segment_pin_enable);
   endproperty
   a_seg_hold: assert property (p_seg_hold) else $error("segment enable drifted");

   property p_pix_hold;
      @(posedge core_clk) disable iff (reset)
      !wr_pixel |=> $stable(pixel_on_bit);
   endproperty
   a_pix_hold: assert property (p_pix_hold) else $error("pixel drifted");

   // Zero outside read cycles lets software OR several ports without a mux
   property p_rd_idle;
      @(posedge core_clk) disable iff (reset)
      !reg_rd |=> reg_rdata == 8'h00;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");

   sequence s_rd_status;
      reg_rd && reg_addr == ADDR_STATUS;
   endsequence

   property p_status_rd;
      @(posedge core_clk) disable iff (reset)
      s_rd_status |=> reg_rdata[7:3] == 5'h00;
   endproperty
   a_status_rd: assert property (p_status_rd) else $error("status spare bits set");

   // Clock chain, power and bias level checks
   property p_restart_pulse;
      @(posedge core_clk) disable iff (reset)
      (wr_prescale && (reg_wdata[3:0] != frame_prescale_select)) |=> restart_r;
   endproperty
   a_restart_pulse: assert property (p_restart_pulse) else $error("no restart");

   // A reserved code must stay silent so a stray value never clocks the glass
   property p_rsvd_quiet;
      @(posedge core_clk) disable iff (reset)
      (src_sel == SRC_RSVD) |=> !frame_tick;
   endproperty
   a_rsvd_quiet: assert property (p_rsvd_quiet) else $error("reserved source ticked");

   property p_sys_sleep_off;
      @(posedge core_clk) disable iff (reset)
      (lcd_enable && cpu_sleep && src_sel == SRC_SYS_DIV) |=> !lcd_active_flag;
   endproperty
   a_sys_sleep_off: assert property (p_sys_sleep_off) else $error("active in sleep");

   property p_levels_static;
      @(posedge core_clk) disable iff (reset)
      (bias_sel == BIAS_STATIC) |-> bias_levels_m1 == 2'd1;
   endproperty
   a_levels_static: assert property (p_levels_static) else $error("static levels wrong");

   property p_levels_third;
      @(posedge core_clk) disable iff (reset)
      (bias_sel == BIAS_THIRD) |-> bias_levels_m1 == 2'd3;
   endproperty
   a_levels_third: assert property (p_levels_third) else $error("third levels wrong");
endmodule : lccs_top

// ===== lccs_top_tb_top.sv
// Purpose: Self-checking bench for the LCD clock, contrast and segment block
// Assumes: Register port answers in the cycle after the read strobe
// Notes:   Oscillator ticks are driven by hand as one-cycle pulses
`timescale 1ns/10ps
module lccs_top_tb_top;
   import lccs_pkg::*;
   logic       core_clk = 1'b0;
   logic       reset, reg_wr, reg_rd, cpu_sleep;
   logic       xtal_tick, lfosc_tick, xtal_enabled, frame_tick;
   logic       ladder_short, bias_ladder_on, mid_resistor_short, lcd_active_flag;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, segment_pin_enable, pixel_on_bit, rv;
   logic [2:0] ladder_tap;
   logic [1:0] bias_levels_m1;
   int         fails, check_count, frames, f0, n;

   lccs_top i_lccs_top (.core_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .cpu_sleep, .xtal_tick, .lfosc_tick, .xtal_enabled, .frame_tick,
      .ladder_tap, .ladder_short, .segment_pin_enable, .pixel_on_bit, .bias_levels_m1,
      .bias_ladder_on, .mid_resistor_short, .lcd_active_flag);

   ////////////////////////////////////////////////////////////////////////////
   // Clock and a running count of frame ticks, sampled on the clock
   always #2.5 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      if (frame_tick === 1'b1) frames <= frames + 1;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic results;
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : results

   // One-cycle write strobe; taken at the following edge
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : wr

   // Read data stands only in the cycle after the strobe, so sample it there
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a; reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd

   task automatic step;
      repeat (2) @(posedge core_clk);
      #1;
   endtask : step

   // Disable first so a leftover prescaler count never leaks into a test
   task automatic cfg(input logic [1:0] src, input logic [3:0] ratio);
      wr(ADDR_CONTROL, 8'h00);
      wr(ADDR_PRESCALE, {4'h0, ratio});
      wr(ADDR_CONTROL, {6'h04, src});
      repeat (4) @(posedge core_clk);
   endtask : cfg

   task automatic ticks(input int cnt, input logic lf);
      repeat (cnt) begin
         @(posedge core_clk);
         if (lf) lfosc_tick <= 1'b1;
         else xtal_tick <= 1'b1;
         @(posedge core_clk);
         lfosc_tick <= 1'b0; xtal_tick <= 1'b0;
         @(posedge core_clk);
      end
      repeat (3) @(posedge core_clk);
   endtask : ticks

   // Bounded wait for the next frame tick, counting edges
   task automatic wait_frame(output int cnt);
      cnt = 0;
      do begin
         @(posedge core_clk);
         #1;
         cnt++;
      end while (frame_tick !== 1'b1 && cnt < 3000);
      if (cnt >= 3000) begin
         fails++;
         $display("BAD t=%0t no frame tick", $time);
         results();
      end
   endtask : wait_frame

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      for (int a = 0; a < 6; a++) begin
         rd(a[3:0], rv);
         chk(rv, (a == 5) ? 8'h04 : 8'h00);
      end
      chk({7'h0, ladder_short}, 8'h01);
      chk({6'h0, bias_levels_m1}, 8'h01);
      chk({7'h0, bias_ladder_on}, 8'h00);
      $display("reset test done");
   endtask : t_reset

   task automatic t_contrast;
      for (int i = 0; i < 8; i++) begin
         wr(ADDR_CONTRAST, {5'h1f, i[2:0]});
         rd(ADDR_CONTRAST, rv);
         chk(rv, {5'h00, i[2:0]});
         chk({5'h0, ladder_tap}, {5'h0, i[2:0]});
         chk({7'h0, ladder_short}, {7'h0, i == 0});
      end
      $display("contrast test done");
   endtask : t_contrast

   task automatic t_segment;
      wr(ADDR_SEG_EN, 8'ha5);
      wr(ADDR_PIXEL, 8'h3c);
      wr(4'hf, 8'hff);
      step();
      chk(segment_pin_enable, 8'ha5);
      chk(pixel_on_bit, 8'h3c);
      rd(ADDR_SEG_EN, rv);
      chk(rv, 8'ha5);
      rd(ADDR_PIXEL, rv);
      chk(rv, 8'h3c);
      rd(4'hf, rv);
      chk(rv, 8'h00);
      $display("segment test done");
   endtask : t_segment

   task automatic t_bias;
      for (int b = 0; b < 3; b++) begin
         wr(ADDR_CONTROL, {4'h1, b[1:0], 2'h1});
         step();
         chk({6'h0, bias_levels_m1}, b[7:0] + 8'h01);
         chk({7'h0, bias_ladder_on}, 8'h01);
         chk({7'h0, mid_resistor_short}, 8'h00);
      end
      wr(ADDR_CONTROL, 8'h35);
      step();
      chk({7'h0, mid_resistor_short}, 8'h01);
      rd(ADDR_STATUS, rv);
      chk(rv, 8'h05);
      wr(ADDR_CONTROL, 8'hff);
      rd(ADDR_CONTROL, rv);
      chk(rv, 8'h7f);
      wr(ADDR_CONTROL, 8'h00);
      step();
      chk({6'h0, bias_ladder_on, lcd_active_flag}, 8'h00);
      $display("bias test done");
   endtask : t_bias

   // Each listed oscillator source and ratio: 3*(r+1) source ticks give exactly three frames
   task automatic t_frames;
      logic [1:0] src [5] = '{2'h1, 2'h1, 2'h1, 2'h2, 2'h2};
      logic [3:0] rat [5] = '{4'h0, 4'h1, 4'hf, 4'h2, 4'h0};
      for (int k = 0; k < 5; k++) begin
         cfg(src[k], rat[k]);
         cpu_sleep <= (k >= 3);
         f0 = frames;
         ticks(3 * (rat[k] + 1), src[k] == 2'h2);
         chk(8'(frames - f0), 8'h03);
      end
      cpu_sleep <= 1'b0;
      cfg(2'h3, 4'h0);
      f0 = frames;
      ticks(4, 1'b0);
      ticks(4, 1'b1);
      chk(8'(frames - f0), 8'h00);
      cfg(2'h1, 4'hf);
      ticks(10, 1'b0);
      wr(ADDR_PRESCALE, 8'h03);
      repeat (3) @(posedge core_clk);
      f0 = frames;
      // Seven ticks after a restart give one frame; a stale count would give two
      ticks(7, 1'b0);
      chk(8'(frames - f0), 8'h01);
      $display("frame test done");
   endtask : t_frames

   task automatic t_sysclk;
      cfg(2'h0, 4'h1);
      wait_frame(n);
      wait_frame(n);
      chk(8'(n / SYS_DIV), 8'h02);
      chk(8'(n % SYS_DIV), 8'h00);
      @(posedge core_clk);
      cpu_sleep <= 1'b1;
      repeat (20) @(posedge core_clk);
      f0 = frames;
      repeat (600) @(posedge core_clk);
      #1;
      chk(8'(frames - f0), 8'h00);
      chk({7'h0, lcd_active_flag}, 8'h00);
      @(posedge core_clk);
      cpu_sleep <= 1'b0;
      $display("system clock test done");
   endtask : t_sysclk

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      reset = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0;
      reg_addr = 4'h0; reg_wdata = 8'h00; cpu_sleep = 1'b0;
      xtal_tick = 1'b0; lfosc_tick = 1'b0;
      xtal_enabled = 1'b1;
      fails = 0; check_count = 0;
      repeat (10) @(posedge core_clk);
      reset <= 1'b0;
      t_reset();
      t_contrast();
      t_segment();
      t_bias();
      t_frames();
      t_sysclk();
      results();
   end
endmodule : lccs_top_tb_top
